// File: rx_frame_source.sv
// receive path model that hands per-frame status to the statistics block
`timescale 1ns/1ns
module rx_frame_source (
    input wire sys_clk,
    output reg frame_start,
    output reg frame_end,
    output reg [15:0] frame_length,
    output reg [47:0] frame_dest_addr,
    output reg [15:0] frame_type,
    output reg [15:0] frame_opcode,
    output reg frame_addr_match,
    output reg frame_odd_nibbles,
    output reg frame_fcs_fail,
    output reg frame_overrun,
    output reg rx_error_input
);
    // ****************************************************************
    // frame sequencing
    // ****************************************************************
    // quiet lines at time zero
    initial begin
        {frame_start, frame_end, rx_error_input, frame_length, frame_dest_addr} = 67'd0;
        {frame_type, frame_opcode, frame_addr_match, frame_odd_nibbles} = 34'd0;
        {frame_fcs_fail, frame_overrun} = 2'b00;
    end
    // fl holds match, odd nibbles, fcs fail, overrun, rx error
    task send(input [15:0] len, input [47:0] da, input [15:0] ty, input [15:0] op,
        input [4:0] fl);
        begin
            @(posedge sys_clk) frame_start <= 1'b1;
            @(posedge sys_clk) frame_start <= 1'b0;
            rx_error_input <= fl[0];
            @(posedge sys_clk) rx_error_input <= 1'b0;
            {frame_length, frame_dest_addr, frame_type, frame_opcode} <= {len, da, ty, op};
            {frame_addr_match, frame_odd_nibbles, frame_fcs_fail, frame_overrun} <= fl[4:1];
            frame_end <= 1'b1;
            // fields are stale after the strobe, so invert length, address, type and opcode to expose late sampling
            @(posedge sys_clk) frame_end <= 1'b0;
            {frame_length, frame_dest_addr, frame_type, frame_opcode} <= ~{len, da, ty, op};
        end
    endtask
endmodule

// File: rx_stats_counters.v
// receive statistics counter bank with apb slave and interrupt
//
// Behaviour
// R1 - counters cleared 38 clocks after reset
// R2 - gigabit mode: write subtracts from count
// R3 - decrement below zero gives zero
// R4 - normal mode: write loads count directly
// R5 - software writes counters with full words
// R6 - interrupt when any count reaches 8000_0000
// R7 - interrupt holds until counts decremented below
// R8 - counters 32 bits, wrap without saturating
// R9 - good frame: matched, length ok, error free
// R10 - broadcast: good frame to all-ones address
// R11 - multicast: good group frame, not broadcast
// R12 - pause: type 8808, opcode 0001, good
// R13 - pause counted only with flow control on
// R14 - crc error: matched, length ok, even nibbles
// R15 - overrun ignored by all counters
// R16 - odd nibbles with bad check: alignment error
// R17 - rx error input during frame: code error
// R18 - each counter once per frame at end
// R19 - write and increment together both applied
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "rx_stats_defs.vh"

module rx_stats_counters #(
    parameter NUM_COUNTERS = 5
) (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire frame_start,
    input wire frame_end,
    input wire [15:0] frame_length,
    input wire [47:0] frame_dest_addr,
    input wire [15:0] frame_type,
    input wire [15:0] frame_opcode,
    input wire frame_addr_match,
    input wire frame_odd_nibbles,
    input wire frame_fcs_fail,
    input wire frame_overrun,
    input wire rx_error_input,
    output wire stats_interrupt_pending,
    output wire irq
);

    // ****************************************************************
    // control registers
    // ****************************************************************
    reg [2:0] mac_control_register;
    reg [15:0] rx_max_frame_length;
    reg [NUM_COUNTERS-1:0] irq_status;
    reg [NUM_COUNTERS-1:0] irq_mask;
    reg [5:0] clear_cnt;
    reg clearing;
    reg code_err_seen;
    reg [31:0] count [0:NUM_COUNTERS-1];

    wire gigabit_interface_enable = mac_control_register[`CTL_GIGABIT_BIT];
    wire tx_flow_control_enable = mac_control_register[`CTL_TX_FLOW_BIT];
    wire stats_irq_enable = mac_control_register[`CTL_STATS_IRQ_EN_BIT];

    // apb phases; slave always ready so every access ends in one access cycle
    wire access = psel & penable;
    wire wr = access & pwrite;
    assign pready = 1'b1;
    // partial writes to counters are refused with an error answer
    wire cnt_addr = (paddr <= `ADDR_CRC) && (paddr[1:0] == 2'b00);
    wire known_addr = cnt_addr || paddr == `ADDR_MAC_CONTROL || paddr == `ADDR_MAX_LEN ||
                      paddr == `ADDR_IRQ_STATUS || paddr == `ADDR_IRQ_MASK ||
                      paddr == `ADDR_PEND_STATUS;
    wire partial_cnt_wr = wr && cnt_addr && (pstrb != 4'hF); // [R5]
    assign pslverr = access & (~known_addr | partial_cnt_wr);

    // ****************************************************************
    // frame classification
    // ****************************************************************
    // rx error seen after the start strobe cycle, up to and including the end strobe, marks a code error
    always @(posedge sys_clk) begin
        if (rst || frame_start)
            code_err_seen <= 1'b0;
        else if (rx_error_input)
            code_err_seen <= 1'b1; // [R17]
    end

    wire code_err = code_err_seen | rx_error_input; // [R17]
    wire align_err = frame_odd_nibbles & frame_fcs_fail; // [R16]
    wire crc_err = ~frame_odd_nibbles & frame_fcs_fail;
    wire len_ok = (frame_length >= `MIN_FRAME_LEN) && (frame_length <= rx_max_frame_length);
    // overrun deliberately takes no part in any term below
    wire good = frame_end & frame_addr_match & len_ok & ~crc_err & ~align_err & ~code_err; // [R9] [R15]
    wire is_bcast = frame_dest_addr == `BCAST_ADDR;
    wire is_group = frame_dest_addr[40];
    wire [NUM_COUNTERS-1:0] inc;
    assign inc[0] = good; // [R9] [R18]
    assign inc[1] = good & is_bcast; // [R10]
    assign inc[2] = good & is_group & ~is_bcast; // [R11]
    assign inc[3] = good & tx_flow_control_enable & (frame_type == `PAUSE_TYPE) &
                    (frame_opcode == `PAUSE_OPCODE); // [R12] [R13]
    assign inc[4] = frame_end & frame_addr_match & len_ok & ~align_err & ~code_err &
                    crc_err; // [R14]

    // ****************************************************************
    // reset clear sequence
    // ****************************************************************
    // counters are held at zero until the clear delay after reset has run out
    always @(posedge sys_clk) begin
        if (rst) begin
            clear_cnt <= `CLEAR_CNT_ZERO;
            clearing <= 1'b1;
        end else if (clearing) begin
            clear_cnt <= clear_cnt + `CLEAR_CNT_ONE;
            if (clear_cnt == `CLEAR_CYCLES - `CLEAR_CNT_ONE)
                clearing <= 1'b0; // [R1]
        end
    end

    // ****************************************************************
    // counter bank
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < NUM_COUNTERS; i = i + 1) begin : g_cnt
            wire hit = wr && (pstrb == 4'hF) && (paddr == (i * 4)); // [R5]
            wire [31:0] inc_val = inc[i] ? `COUNT_ONE : `COUNT_ZERO;
            wire [31:0] base = count[i] + inc_val; // [R8] [R19]
            reg [31:0] next_count;
            // write and increment in the same cycle both land
            always @* begin
                next_count = base;
                if (hit) begin
                    if (gigabit_interface_enable)
                        next_count = (pwdata > base) ? `COUNT_ZERO : base - pwdata; // [R2] [R3]
                    else
                        next_count = pwdata + inc_val; // [R4] [R19]
                end
            end
            always @(posedge sys_clk) begin
                if (rst || clearing)
                    count[i] <= `COUNT_ZERO; // [R1]
                else
                    count[i] <= next_count; // [R8]
            end
        end
    endgenerate

    // ****************************************************************
    // pending flags and interrupt
    // ****************************************************************
    wire [NUM_COUNTERS-1:0] pend;
    genvar j;
    generate
        for (j = 0; j < NUM_COUNTERS; j = j + 1) begin : g_pend
            assign pend[j] = count[j][31]; // [R6] [R7]
        end
    endgenerate
    // level follows counts and the enable, so it drops once every high count is brought down or the enable is cleared
    assign stats_interrupt_pending = stats_irq_enable & (|pend); // [R6] [R7]
    assign irq = |(irq_status & irq_mask);

    // ****************************************************************
    // control and interrupt registers
    // ****************************************************************
    // sticky status: a newly pending counter sets its bit, set beats clear
    always @(posedge sys_clk) begin
        if (rst) begin
            mac_control_register <= 3'b000;
            rx_max_frame_length <= `MAX_LEN_RESET;
            irq_status <= {NUM_COUNTERS{1'b0}};
            irq_mask <= {NUM_COUNTERS{1'b0}};
        end else begin
            if (wr && paddr == `ADDR_MAC_CONTROL)
                mac_control_register <= pwdata[2:0];
            if (wr && paddr == `ADDR_MAX_LEN)
                rx_max_frame_length <= pwdata[15:0];
            if (wr && paddr == `ADDR_IRQ_MASK)
                irq_mask <= pwdata[NUM_COUNTERS-1:0];
            if (wr && paddr == `ADDR_IRQ_STATUS)
                irq_status <= (irq_status & ~pwdata[NUM_COUNTERS-1:0]) | pend;
            else
                irq_status <= irq_status | pend;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // read data registered at the setup cycle so it is valid in the access cycle
    always @(posedge sys_clk) begin
        if (rst) begin
            prdata <= `WORD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            if (cnt_addr)
                prdata <= count[paddr[4:2]];
            else if (paddr == `ADDR_MAC_CONTROL)
                prdata <= {29'h0, mac_control_register};
            else if (paddr == `ADDR_MAX_LEN)
                prdata <= {16'h0000, rx_max_frame_length};
            else if (paddr == `ADDR_IRQ_STATUS)
                prdata <= {{(32-NUM_COUNTERS){1'b0}}, irq_status};
            else if (paddr == `ADDR_IRQ_MASK)
                prdata <= {{(32-NUM_COUNTERS){1'b0}}, irq_mask};
            else if (paddr == `ADDR_PEND_STATUS)
                prdata <= {{(32-NUM_COUNTERS){1'b0}}, pend};
            else
                prdata <= `WORD_ZERO;
        end
    end

endmodule

// File: rx_stats_defs.vh
// register map, field positions and timing constants of the receive statistics block
`ifndef RX_STATS_DEFS_VH
`define RX_STATS_DEFS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_GOOD 12'h000
`define ADDR_BCAST 12'h004
`define ADDR_MCAST 12'h008
`define ADDR_PAUSE 12'h00C
`define ADDR_CRC 12'h010
`define ADDR_MAC_CONTROL 12'h020
`define ADDR_MAX_LEN 12'h024
`define ADDR_IRQ_STATUS 12'h028
`define ADDR_IRQ_MASK 12'h02C
`define ADDR_PEND_STATUS 12'h030

// ****************************************************************
// fields and values
// ****************************************************************
`define CTL_GIGABIT_BIT 0
`define CTL_TX_FLOW_BIT 1
`define CTL_STATS_IRQ_EN_BIT 2
`define MAX_LEN_RESET 16'h05EE
`define MIN_FRAME_LEN 16'h0040
`define PAUSE_TYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`define BCAST_ADDR 48'hFFFF_FFFF_FFFF
`define COUNT_ZERO 32'h0000_0000
`define COUNT_ONE 32'h0000_0001
`define WORD_ZERO 32'h0000_0000
`define CLEAR_CYCLES 6'h26
`define CLEAR_CNT_ZERO 6'h00
`define CLEAR_CNT_ONE 6'h01

`endif

// File: rx_stats_monitor.sv
// bus and interrupt checker for the receive statistics block
`timescale 1ns/1ns
module rx_stats_monitor (
    input wire sys_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire frame_end,
    input wire stats_interrupt_pending
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a write access and a counter write of either width
    sequence s_wr;
        psel && penable && pwrite;
    endsequence
    sequence s_cnt_wr;
        s_wr ##0 (paddr <= 12'h010);
    endsequence
    a_reset_quiet: assert property ($fell(rst) |-> !stats_interrupt_pending)
        else $error("pending set right after reset");
    a_reset_data: assert property ($fell(rst) |-> prdata == 32'h0000_0000)
        else $error("read data not zero after reset");
    a_part_write: assert property (s_cnt_wr ##0 (pstrb != 4'hF) |-> pslverr)
        else $error("partial counter write not refused");
    // only aligned counter words are mapped; an odd byte address is refused anyway
    a_full_write: assert property (s_cnt_wr ##0 (pstrb == 4'hF) ##0 (paddr[1:0] == 2'b00)
        |-> !pslverr)
        else $error("full counter write refused");
    a_bus_ready: assert property (psel && penable |-> pready)
        else $error("access not answered in one cycle");
    // pending only moves on a write or a frame end; a stale level would hide events
    a_pend_hold: assert property (stats_interrupt_pending && !(psel && pwrite) && !frame_end
        |=> stats_interrupt_pending)
        else $error("pending dropped without a write");
    a_pend_cause: assert property ($rose(stats_interrupt_pending)
        |-> $past(frame_end) || $past(psel && penable && pwrite))
        else $error("pending rose without a cause");
    a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
endmodule

bind rx_stats_counters rx_stats_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_end(frame_end),
    .stats_interrupt_pending(stats_interrupt_pending));

// File: tb_ethernet_rx_statistics_counters.sv
// self-checking bench for the receive statistics counter bank
`timescale 1ns/1ns
`include "rx_stats_defs.vh"
module tb_ethernet_rx_statistics_counters;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000, rd;
    reg [3:0] pstrb = 4'hF;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, frame_start, frame_end, frame_addr_match, frame_odd_nibbles;
    wire frame_fcs_fail, frame_overrun, rx_error_input, stats_interrupt_pending, irq;
    wire [15:0] frame_length, frame_type, frame_opcode;
    wire [47:0] frame_dest_addr;
    integer miscompares = 0, total_checks = 0, cycles = 0, i;
    localparam [47:0] uni = 48'h0000_1234_5678, mc = 48'h0100_0000_0001;
    rx_stats_counters i_dut (.*);
    rx_frame_source i_src (.*);
    // ****************************************************************
    // clock, timeout and shared tasks
    // ****************************************************************
    always #5 sys_clk = ~sys_clk;
    // a hung handshake must still end in the verdict
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    task results;
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("Error %0s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        begin
            @(posedge sys_clk) {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
            @(posedge sys_clk) penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) @(posedge sys_clk);
            rd = prdata;
            err = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    task rdc(input string n, input [11:0] a, input [31:0] e);
        apb(1'b0, a, `WORD_ZERO, 4'hF);
        chk(n, e, rd);
    endtask
    task good(input [47:0] da, input [15:0] len, input [4:0] fl);
        i_src.send(len, da, 16'h0800, 16'h0000, fl);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        good(uni, `MIN_FRAME_LEN, 5'b10000);
        repeat (40) @(posedge sys_clk);
        for (i = 0; i < 5; i = i + 1) rdc("count", i * 4, `COUNT_ZERO);
    endtask
    task t_classify;
        apb(1'b1, `ADDR_MAC_CONTROL, 32'h0000_0002, 4'hF);
        good(uni, `MIN_FRAME_LEN, 5'b10000);
        good(`BCAST_ADDR, `MIN_FRAME_LEN, 5'b10000);
        good(mc, `MIN_FRAME_LEN, 5'b10000);
        i_src.send(`MIN_FRAME_LEN, uni, `PAUSE_TYPE, `PAUSE_OPCODE, 5'b10000);
        good(uni, `MIN_FRAME_LEN, 5'b10100);
        good(uni, `MIN_FRAME_LEN, 5'b11100);
        good(uni, `MIN_FRAME_LEN, 5'b10001);
        good(uni, 16'h003F, 5'b10000);
        good(uni, `MAX_LEN_RESET, 5'b10000);
        good(uni, 16'h05EF, 5'b10000);
        good(uni, `MIN_FRAME_LEN, 5'b10010);
        good(uni, `MIN_FRAME_LEN, 5'b00000);
        apb(1'b1, `ADDR_MAC_CONTROL, `WORD_ZERO, 4'hF);
        i_src.send(`MIN_FRAME_LEN, uni, `PAUSE_TYPE, `PAUSE_OPCODE, 5'b10000);
        rdc("good", `ADDR_GOOD, 32'h0000_0007);
        rdc("bcast", `ADDR_BCAST, `COUNT_ONE);
        rdc("mcast", `ADDR_MCAST, `COUNT_ONE);
        rdc("pause", `ADDR_PAUSE, `COUNT_ONE);
        rdc("crc", `ADDR_CRC, `COUNT_ONE);
    endtask
    task t_write;
        apb(1'b1, `ADDR_GOOD, 32'hFFFF_FFFF, 4'hF);
        good(uni, `MIN_FRAME_LEN, 5'b10000);
        rdc("wrap", `ADDR_GOOD, `COUNT_ZERO);
        apb(1'b1, `ADDR_BCAST, 32'h0000_000A, 4'hF);
        apb(1'b1, `ADDR_MAC_CONTROL, `COUNT_ONE, 4'hF);
        apb(1'b1, `ADDR_BCAST, 32'h0000_0003, 4'hF);
        rdc("decrement", `ADDR_BCAST, 32'h0000_0007);
        apb(1'b1, `ADDR_BCAST, 32'hFFFF_FFFF, 4'hF);
        rdc("floor", `ADDR_BCAST, `COUNT_ZERO);
        apb(1'b1, `ADDR_MAC_CONTROL, `WORD_ZERO, 4'hF);
        apb(1'b1, `ADDR_MCAST, `WORD_ZERO, 4'hF);
        rdc("direct", `ADDR_MCAST, `COUNT_ZERO);
        apb(1'b1, `ADDR_PAUSE, `WORD_ZERO, 4'h3);
        chk("part_err", `COUNT_ONE, {31'd0, err});
        rdc("part", `ADDR_PAUSE, `COUNT_ONE);
        rdc("unmapped", 12'h014, `WORD_ZERO);
        chk("map_err", `COUNT_ONE, {31'd0, err});
    endtask
    task t_irq;
        apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_001F, 4'hF);
        apb(1'b1, `ADDR_GOOD, 32'h8000_0000, 4'hF);
        @(negedge sys_clk) chk("pend_off", `COUNT_ZERO, {31'd0, stats_interrupt_pending});
        apb(1'b1, `ADDR_MAC_CONTROL, 32'h0000_0004, 4'hF);
        @(negedge sys_clk) chk("pend", `COUNT_ONE, {31'd0, stats_interrupt_pending});
        chk("irq", `COUNT_ONE, {31'd0, irq});
        rdc("pend_view", `ADDR_PEND_STATUS, `COUNT_ONE);
        rdc("irq_status", `ADDR_IRQ_STATUS, `COUNT_ONE);
        apb(1'b1, `ADDR_MAC_CONTROL, 32'h0000_0005, 4'hF);
        apb(1'b1, `ADDR_GOOD, `COUNT_ONE, 4'hF);
        @(negedge sys_clk) chk("pend_clr", `COUNT_ZERO, {31'd0, stats_interrupt_pending});
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h0000_001F, 4'hF);
        @(negedge sys_clk) chk("irq_clr", `COUNT_ZERO, {31'd0, irq});
    endtask
    // reset, then the scenarios in order
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_classify;
        t_write;
        t_irq;
        results;
    end
endmodule
